// *** core/relay_ctl_regs.vh ***
// Constants shared by the relay output control design files.
`ifndef RELAY_CTL_REGS_VH
`define RELAY_CTL_REGS_VH
`define SRC_ALARM1 2'h0
`define SRC_ALARM2 2'h1
`define SRC_BOTH 2'h2
`define SRC_NONE 2'h3
`define FUNC_OR 1'h0
`define FUNC_AND 1'h1
`define POL_NO 1'h0
`define POL_NC 1'h1
`define TICK_NS 1000000
`define CLK_NS 8
`endif

// *** core/chan_alarm.v ***
// Two threshold alarms with hysteresis for one measurement channel.
`timescale 1ns/1ns
module chan_alarm #(
  parameter W = 16
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] reading,
  input wire [W-1:0] thr1,
  input wire [W-1:0] hyst1,
  input wire under1,
  input wire [W-1:0] thr2,
  input wire [W-1:0] hyst2,
  input wire under2,
  output wire [1:0] alarm
);
  reg [1:0] alarm_r;
  reg [1:0] alarm_nxt;
  reg [W:0] hi1;
  reg [W:0] lo1;
  reg [W:0] hi2;
  reg [W:0] lo2;
  reg [W:0] rd;

  assign alarm = alarm_r;

  // Each alarm sets past one hysteresis edge and clears past the other.
  always @* begin
    rd = {1'b0, reading};
    hi1 = {1'b0, thr1} + {1'b0, hyst1};
    lo1 = {1'b0, thr1} - {1'b0, hyst1};
    hi2 = {1'b0, thr2} + {1'b0, hyst2};
    lo2 = {1'b0, thr2} - {1'b0, hyst2};
    alarm_nxt = alarm_r;
    if (!under1) begin
      if (rd > hi1) alarm_nxt[0] = 1'b1;
      else if (rd < lo1 && !lo1[W]) alarm_nxt[0] = 1'b0;
    end else begin
      if (rd < lo1 && !lo1[W]) alarm_nxt[0] = 1'b1;
      else if (rd > hi1) alarm_nxt[0] = 1'b0;
    end
    if (!under2) begin
      if (rd > hi2) alarm_nxt[1] = 1'b1;
      else if (rd < lo2 && !lo2[W]) alarm_nxt[1] = 1'b0;
    end else begin
      if (rd < lo2 && !lo2[W]) alarm_nxt[1] = 1'b1;
      else if (rd > hi2) alarm_nxt[1] = 1'b0;
    end
  end

  // Alarms start cleared.
  always @(posedge clk) begin
    if (!nrst) alarm_r <= 2'h0;
    else alarm_r <= alarm_nxt;
  end
endmodule

// *** core/relay_ctl.v ***
// Relay output control: channel alarms, logic function, delays and hold times.
`timescale 1ns/1ns
`include "relay_ctl_regs.vh"
// Functional notes
// - Every channel has two alarms, each set independently by its own condition.
// - Each output combines its attached channels with OR (any) or AND (all).
// - A source naming one alarm puts the channel in alarm exactly when that alarm is set.
// - A source naming both alarms needs both set at the same time.
// - Normally open polarity closes the relay while the function is 1.
// - Normally closed polarity opens the relay while the function is 1.
// - A zero delay lets the relay follow the function at once.
// - A nonzero delay switches the relay only after the delay has run out.
// - After a switch the relay holds its state for the closed or open hold time.
// - No delay counting happens while a hold time runs.
// - The delay counter counts up while the function differs from the coil state and down to 0 while they agree.
// - Each relay has its own open or closed status output.
module relay_ctl #(
  parameter NCH = 2,
  parameter NOUT = 2,
  parameter W = 16,
  parameter TW = 16,
  parameter TICK_CYC = `TICK_NS / `CLK_NS
) (
  input wire clk,
  input wire nrst,
  input wire [NCH*W-1:0] reading,
  input wire [NCH*W-1:0] thr1,
  input wire [NCH*W-1:0] hyst1,
  input wire [NCH-1:0] under1,
  input wire [NCH*W-1:0] thr2,
  input wire [NCH*W-1:0] hyst2,
  input wire [NCH-1:0] under2,
  input wire [NOUT*NCH*2-1:0] src_sel,
  input wire [NOUT-1:0] func_and,
  input wire [NOUT-1:0] pol_nc,
  input wire [NOUT*TW-1:0] close_delay,
  input wire [NOUT*TW-1:0] open_delay,
  input wire [NOUT*TW-1:0] closed_hold,
  input wire [NOUT*TW-1:0] open_hold,
  output wire [NCH*2-1:0] alarm,
  output wire [NOUT-1:0] relay_on,
  output wire [NOUT-1:0] relay_closed
);
  reg [31:0] tick_cnt_r;
  reg tick_r;
  reg [NOUT-1:0] func;
  reg [NOUT-1:0] coil_r;
  reg [NOUT*TW-1:0] dcnt_r;
  reg [NOUT*TW-1:0] hold_r;
  reg [NOUT*TW-1:0] dcnt_nxt;
  reg [NOUT*TW-1:0] hold_nxt;
  reg [NOUT-1:0] coil_nxt;
  reg [NOUT-1:0] closed_r;
  reg [1:0] sel;
  reg [1:0] a;
  reg ch_al;
  reg want;
  reg [TW-1:0] dc;
  reg [TW-1:0] hd;
  reg [TW-1:0] dly;
  integer o;
  integer c;
  integer p;
  integer q;

  genvar g;
  // One alarm pair per channel.
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gch
      chan_alarm #(.W(W)) u_al (
        .clk(clk),
        .nrst(nrst),
        .reading(reading[g*W +: W]),
        .thr1(thr1[g*W +: W]),
        .hyst1(hyst1[g*W +: W]),
        .under1(under1[g]),
        .thr2(thr2[g*W +: W]),
        .hyst2(hyst2[g*W +: W]),
        .under2(under2[g]),
        .alarm(alarm[g*2 +: 2])
      );
    end
  endgenerate

  // Time base tick that paces delay and hold counters.
  always @(posedge clk) begin
    if (!nrst) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYC - 1) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // Logic function per output over all attached channels.
  always @* begin
    sel = 2'h0;
    a = 2'h0;
    ch_al = 1'b0;
    for (o = 0; o < NOUT; o = o + 1) begin
      func[o] = func_and[o] == `FUNC_AND;
      for (c = 0; c < NCH; c = c + 1) begin
        sel = src_sel[(o*NCH + c)*2 +: 2];
        a = alarm[c*2 +: 2];
        case (sel)
          `SRC_ALARM1: ch_al = a[0];
          `SRC_ALARM2: ch_al = a[1];
          `SRC_BOTH: ch_al = a[0] & a[1];
          default: ch_al = 1'b0;
        endcase
        if (sel != `SRC_NONE) begin
          if (func_and[o] == `FUNC_AND) func[o] = func[o] & ch_al;
          else func[o] = func[o] | ch_al;
        end
      end
    end
  end

  // Delay counter and hold timer per output; coil means relay in its active state.
  always @* begin
    dcnt_nxt = dcnt_r;
    hold_nxt = hold_r;
    coil_nxt = coil_r;
    dc = {TW{1'b0}};
    hd = {TW{1'b0}};
    dly = {TW{1'b0}};
    want = 1'b0;
    for (p = 0; p < NOUT; p = p + 1) begin
      dc = dcnt_r[p*TW +: TW];
      hd = hold_r[p*TW +: TW];
      want = func[p];
      dly = coil_r[p] ? open_delay[p*TW +: TW] : close_delay[p*TW +: TW];
      if (hd != {TW{1'b0}}) begin
        if (tick_r) hold_nxt[p*TW +: TW] = hd - 1'b1;
      end else if (want != coil_r[p]) begin
        if (dc >= dly) begin
          coil_nxt[p] = want;
          dcnt_nxt[p*TW +: TW] = {TW{1'b0}};
          hold_nxt[p*TW +: TW] = want ? closed_hold[p*TW +: TW] : open_hold[p*TW +: TW];
        end else if (tick_r) begin
          dcnt_nxt[p*TW +: TW] = dc + 1'b1;
        end
      end else if (tick_r && dc != {TW{1'b0}}) begin
        dcnt_nxt[p*TW +: TW] = dc - 1'b1;
      end
    end
  end

  // State registers and relay contact mapping.
  always @(posedge clk) begin
    if (!nrst) begin
      coil_r <= {NOUT{1'b0}};
      dcnt_r <= {NOUT*TW{1'b0}};
      hold_r <= {NOUT*TW{1'b0}};
      closed_r <= {NOUT{1'b0}};
    end else begin
      coil_r <= coil_nxt;
      dcnt_r <= dcnt_nxt;
      hold_r <= hold_nxt;
      for (q = 0; q < NOUT; q = q + 1) begin
        if (pol_nc[q] == `POL_NC) closed_r[q] <= ~coil_nxt[q];
        else closed_r[q] <= coil_nxt[q];
      end
    end
  end

  assign relay_on = closed_r;
  assign relay_closed = closed_r;
endmodule

// *** dv/relay_load.sv ***
// Behavioural relay load switched by the relay drive outputs.
`timescale 1ns/1ns
module relay_load (
  input wire clk,
  input wire [1:0] coil,
  output logic [1:0] contact
);
  // The contact settles one cycle after the coil drive changes.
  always @(posedge clk) begin
    contact <= coil;
  end
endmodule

// *** dv/relay_ctl_monitor.sv ***
// Port-level assertions for the relay output control block.
`timescale 1ns/1ns
module relay_ctl_monitor #(parameter NCH = 2, NOUT = 2, W = 16, TW = 16) (
  input wire clk,
  input wire nrst,
  input wire [NCH*W-1:0] reading,
  input wire [NCH*W-1:0] thr1,
  input wire [NCH*W-1:0] hyst1,
  input wire [NCH-1:0] under1,
  input wire [NOUT*NCH*2-1:0] src_sel,
  input wire [NOUT-1:0] func_and,
  input wire [NOUT-1:0] pol_nc,
  input wire [NOUT*TW-1:0] close_delay,
  input wire [NOUT*TW-1:0] open_delay,
  input wire [NOUT*TW-1:0] closed_hold,
  input wire [NOUT*TW-1:0] open_hold,
  input wire [NCH*2-1:0] alarm,
  input wire [NOUT-1:0] relay_on,
  input wire [NOUT-1:0] relay_closed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Alarm 1 bounds of channel 0; a borrow in lo means the clear level is unreachable.
  wire [W:0] hi = {1'b0, thr1[W-1:0]} + {1'b0, hyst1[W-1:0]};
  wire [W:0] lo = {1'b0, thr1[W-1:0]} - hyst1[W-1:0];
  wire set1 = !under1[0] && {1'b0, reading[W-1:0]} > hi;
  wire clr1 = !under1[0] && !lo[W] && reading[W-1:0] < lo[W-1:0];
  // Zero-time follow setup and the close delay setup used by the bench.
  wire zc = nrst && ~|{close_delay, open_delay, closed_hold, open_hold} &&
    src_sel[7:0] == 8'hdc && func_and[1:0] == 2'h2 && pol_nc[1:0] == 2'h2;
  wire d3 = nrst && src_sel[3:0] == 4'hc && !func_and[0] && !pol_nc[0] &&
    ~|{closed_hold, open_hold} && close_delay[TW-1:0] == 3;
  sequence held_closed;
    relay_on[0] [*2];
  endsequence
  sequence stays_open;
    !relay_on[0] [*2];
  endsequence
  reset_clears_a: assert property ($rose(nrst) |-> !(|alarm) && !(|relay_on))
    else $error("outputs not cleared by reset");
  status_match_a: assert property (relay_closed == relay_on)
    else $error("status differs from drive");
  over_sets_a: assert property (set1 |=> alarm[0])
    else $error("over alarm did not set");
  over_clears_a: assert property (clr1 |=> !alarm[0])
    else $error("over alarm did not clear");
  follow_open_a: assert property ($past(zc) |-> relay_on[0] == $past(alarm[0]))
    else $error("open relay did not follow");
  follow_inv_a: assert property ($past(zc) |-> relay_on[1] == !$past(alarm[1]))
    else $error("closed relay did not follow");
  delay_wait_a: assert property (d3 && $rose(alarm[0]) && !relay_on[0] |=> stays_open)
    else $error("close delay ignored");
  hold_keeps_a: assert property ($rose(relay_on[0]) && closed_hold[TW-1:0] >= 3 |=> held_closed)
    else $error("closed hold cut short");
endmodule
bind relay_ctl relay_ctl_monitor #(.NCH(NCH), .NOUT(NOUT), .W(W), .TW(TW)) mon (.*);

// *** dv/test_alarm_relay_output_control.sv ***
// Self-checking testbench for the relay output control block.
`timescale 1ns/1ns
module test_alarm_relay_output_control;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] reading = 32'h0, thr1 = 32'h64, hyst1 = 32'ha, thr2 = 32'h32, hyst2 = 32'h5;
  logic [31:0] close_delay = 32'h0, open_delay = 32'h0, closed_hold = 32'h0, open_hold = 32'h0;
  logic [1:0] under1 = 2'h0, under2 = 2'h1, func_and = 2'h2, pol_nc = 2'h2;
  logic [7:0] src_sel = 8'hff;
  wire [3:0] alarm;
  wire [1:0] relay_on, relay_closed, contact;
  int n_errors = 0;
  int n_tests = 0;
  // An 8 ns clock, the block with a two-cycle tick, and the relay load.
  always #4 clk = ~clk;
  relay_ctl #(.TICK_CYC(2)) uut (.*);
  relay_load load (.clk(clk), .coil(relay_on), .contact(contact));
  task chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Channel 0 reading changes at a falling edge, then n cycles pass.
  task rd(input logic [15:0] v, input int n);
    reading[15:0] = v;
    repeat (n) @(negedge clk);
  endtask
  task wait_r0(input logic v);
    int i;
    for (i = 0; i < 40 && relay_on[0] !== v; i++) @(negedge clk);
    chk({3'h0, relay_on[0]}, {3'h0, v});
    if (i == 40) tally_and_finish();
  endtask
  task t_alarm;
    logic [15:0] v [5] = '{16'h6e, 16'h6f, 16'h5a, 16'h59, 16'h2c};
    logic [1:0] e [5] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h2};
    rd(16'h0, 2);
    chk({alarm[1:0], relay_on}, 4'h0);
    nrst = 1'b1;
    for (int k = 0; k < 5; k++) begin
      rd(v[k], 2);
      chk({2'h0, alarm[1:0]}, {2'h0, e[k]});
    end
    $display("alarm test done");
  endtask
  task t_follow;
    src_sel = 8'hdc;
    rd(16'h2c, 2);
    chk({relay_closed, relay_on}, 4'h0);
    rd(16'h6f, 3);
    chk({contact, relay_on}, 4'hf);
    under2 = 2'h0;
    src_sel = 8'hde;
    rd(16'h6f, 3);
    chk({2'h0, relay_on}, 4'h1);
    rd(16'h59, 3);
    chk({2'h0, relay_on}, 4'h0);
    $display("follow test done");
  endtask
  task t_delay;
    src_sel = 8'hdc;
    close_delay[15:0] = 16'h3;
    rd(16'h6f, 3);
    chk({3'h0, relay_on[0]}, 4'h0);
    rd(16'h59, 4);
    rd(16'h6f, 4);
    chk({3'h0, relay_on[0]}, 4'h0);
    wait_r0(1'b1);
    $display("delay test done");
  endtask
  task t_hold;
    close_delay[15:0] = 16'h0;
    rd(16'h59, 3);
    closed_hold[15:0] = 16'h4;
    rd(16'h6f, 1);
    wait_r0(1'b1);
    rd(16'h59, 5);
    chk({3'h0, relay_on[0]}, 4'h1);
    wait_r0(1'b0);
    $display("hold test done");
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    t_alarm();
    t_follow();
    t_delay();
    t_hold();
    tally_and_finish();
  end
endmodule
